// File: common/acc_if.sv
// cell-level port between the atm layer and the convergence block
`default_nettype none
interface acc_if;
   logic tx_clk;
   logic rx_clk;
   logic [7:0] tx_cell_data;
   logic tx_cell_start;
   logic tx_enable;
   logic tx_cell_space_avail;
   logic [7:0] rx_cell_data;
   logic rx_cell_start;
   logic rx_cell_valid;
   logic rx_enable;
   logic rx_cell_ready;
   modport dev (
      input tx_clk, rx_clk, tx_cell_data, tx_cell_start, tx_enable, rx_enable,
      output tx_cell_space_avail, rx_cell_data, rx_cell_start, rx_cell_valid, rx_cell_ready
   );
   modport atm (
      output tx_clk, rx_clk, tx_cell_data, tx_cell_start, tx_enable, rx_enable,
      input tx_cell_space_avail, rx_cell_data, rx_cell_start, rx_cell_valid, rx_cell_ready
   );
endinterface : acc_if
`default_nettype wire

// File: common/acc_pkg.sv
// constants of the convergence end of the cell port, also read by the bench; acc_atm uses none
`default_nettype none
package acc_pkg;
   localparam int CELL_LEN = 53;
   localparam int HDR_LEN = 5;
   localparam logic [5:0] LAST_POS = 6'h34;
   localparam logic [5:0] HEC_POS = 6'h04;
   localparam logic [5:0] PAY_POS = 6'h05;
   localparam logic [7:0] HEC_POLY = 8'h07;
   localparam logic [7:0] HEC_COSET = 8'h55;
   localparam logic [31:0] IDLE_HDR = 32'h00000001;
   localparam logic [7:0] IDLE_FILL = 8'h6a;
   localparam logic [2:0] LOCK_GOOD = 3'h5;
   localparam logic [2:0] LOSS_BAD = 3'h7;
   localparam int SCR_LEN = 43;
   typedef enum logic [2:0] {
      DL_SEARCH = 3'h1,
      DL_TENTATIVE = 3'h2,
      DL_LOCKED = 3'h4
   } acc_dl_t;
endpackage : acc_pkg
`default_nettype wire

// File: logic/acc_atm.sv
// atm layer end: makes both port clocks and moves cells to and from the user
`default_nettype none
module acc_atm #(
   parameter int DIV = 12
) (
   // cell port toward the convergence block
   acc_if.atm LINK,
   // core clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // transmit octets from the user
   input wire logic [7:0] USER_TX_DATA,
   input wire logic USER_TX_START,
   input wire logic USER_TX_VALID,
   output logic USER_TX_READY,
   // receive octets to the user
   output logic [7:0] USER_RX_DATA,
   output logic USER_RX_START,
   output logic USER_RX_VALID
);
   localparam logic [7:0] HALF = 8'(DIV / 2 - 1);
   logic [7:0] div_r;
   logic clk_r, fall;
   // one divided clock serves both directions
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         div_r <= 8'h00;
         clk_r <= 1'b0;
      end else begin
         div_r <= (div_r == HALF) ? 8'h00 : div_r + 8'h01;
         if (div_r == HALF) clk_r <= ~clk_r;
      end
   end
   assign LINK.tx_clk = clk_r;
   assign LINK.rx_clk = clk_r;
   // outputs change and inputs are read mid-period, away from the rising edge
   assign fall = (div_r == HALF) && clk_r;
   // an octet is offered only with enable
   assign USER_TX_READY = fall && LINK.tx_cell_space_avail;
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         LINK.tx_enable <= 1'b0;
         LINK.tx_cell_start <= 1'b0;
         LINK.tx_cell_data <= 8'h00;
         LINK.rx_enable <= 1'b0;
      end else if (fall) begin
         LINK.tx_enable <= USER_TX_READY && USER_TX_VALID;
         // first octet of each cell is marked
         // a marker without an accepted octet would realign nothing
         LINK.tx_cell_start <= USER_TX_READY && USER_TX_VALID && USER_TX_START;
         LINK.tx_cell_data <= USER_TX_DATA;
         // receive always permitted once out of reset
         LINK.rx_enable <= 1'b1;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         USER_RX_VALID <= 1'b0;
         USER_RX_START <= 1'b0;
         USER_RX_DATA <= 8'h00;
      end else begin
         USER_RX_VALID <= fall && LINK.rx_cell_valid;
         USER_RX_START <= fall && LINK.rx_cell_start;
         if (fall && LINK.rx_cell_valid) USER_RX_DATA <= LINK.rx_cell_data;
      end
   end
endmodule : acc_atm
`default_nettype wire

// File: logic/acc_conv.sv
// convergence block end: cell port, idle/hec/scrambling, delineation, timing marker
// Functional notes
// - 53-octet cells, independent tx and rx streams
// - overwrite fifth transmit octet with hec
// - octets carried msb first
// - atm layer drives both port clocks
// - each clock follows its own direction's rate; acc_atm drives one divided clock for both
// - start marker flags first octet each way
// - tx space flag only when cell fits
// - rx ready only with complete valid cell
// - tx octets taken only under enable
// - rx octets driven only under enable
// - network side takes 8 khz reference in
// - customer side outputs recovered 8 khz reference
// - dual latency uses two identical ports; acc_conv has a single cell port, no dual latency
// - insert idle cells, drop received idles
// - hec crc xored with 01010101b coset
// - detect header errors, never correct them
// - scramble payload with x^43+1
// - descramble received payload likewise
// - search to tentative on one good hec
// - tentative to locked after five good
// - locked to search after seven bad
`default_nettype none
module acc_conv (
   // cell port, clocked by the atm layer
   acc_if.dev LINK,
   // core clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // octet stream toward the line framing sublayer
   output logic [7:0] LINE_TX_DATA,
   output logic LINE_TX_VALID,
   input wire logic LINE_TX_READY,
   // octet stream from the line framing sublayer
   input wire logic [7:0] LINE_RX_DATA,
   input wire logic LINE_RX_VALID,
   // network timing reference
   input wire logic NET_TIMING_IN,
   output logic NETWORK_TIMING_MARKER,
   input wire logic LINE_NTR_IN,
   output logic NET_TIMING_RECOVERED,
   // status
   output logic CELL_LOCKED
);
   // crc only; a mismatch is reported, never repaired
   function automatic logic [7:0] hec_of(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? acc_pkg::HEC_POLY : 8'h00);
      end
      return c ^ acc_pkg::HEC_COSET;
   endfunction : hec_of

   // self-synchronising x^43+1, msb first; dir=1 descrambles
   function automatic logic [50:0] scr(input logic [42:0] s, input logic [7:0] d,
                                       input logic dir);
      logic [42:0] t;
      logic [7:0] o;
      t = s;
      o = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         o[i] = d[i] ^ t[acc_pkg::SCR_LEN-1];
         t = {t[41:0], dir ? d[i] : o[i]};
      end
      return {t, o};
   endfunction : scr

   // ---------------- link reset synchronisers ----------------
   logic txr_s1_r, txr_s2_r, rxr_s1_r, rxr_s2_r;
   always_ff @(posedge LINK.tx_clk) begin
      txr_s1_r <= RSTN;
      txr_s2_r <= txr_s1_r;
   end
   always_ff @(posedge LINK.rx_clk) begin
      rxr_s1_r <= RSTN;
      rxr_s2_r <= rxr_s1_r;
   end

   // ---------------- transmit, link side ----------------
   logic [7:0] tx_buf [acc_pkg::CELL_LEN];
   logic [5:0] tx_idx_r, tx_wi;
   logic tx_req_r, tx_ack_r, tx_ack_s1_r, tx_ack_s2_r, tx_take;
   // space only while the cell buffer is ours
   assign LINK.tx_cell_space_avail = txr_s2_r && (tx_req_r == tx_ack_s2_r);
   assign tx_take = LINK.tx_enable && LINK.tx_cell_space_avail;
   // start marker realigns the octet index
   assign tx_wi = LINK.tx_cell_start ? 6'h00 : tx_idx_r;
   always_ff @(posedge LINK.tx_clk) begin
      tx_ack_s1_r <= tx_ack_r;
      tx_ack_s2_r <= tx_ack_s1_r;
   end
   // a full 53-octet cell is handed over by toggle
   always_ff @(posedge LINK.tx_clk) begin
      if (!txr_s2_r) begin
         tx_idx_r <= 6'h00;
         tx_req_r <= 1'b0;
      end else if (tx_take) begin
         tx_idx_r <= (tx_wi == acc_pkg::LAST_POS) ? 6'h00 : tx_wi + 6'h01;
         if (tx_wi == acc_pkg::LAST_POS) tx_req_r <= ~tx_req_r;
      end
   end
   always_ff @(posedge LINK.tx_clk) begin
      if (tx_take) tx_buf[tx_wi] <= LINK.tx_cell_data;
   end

   // ---------------- transmit, core side ----------------
   logic tx_req_s1_r, tx_req_s2_r, tx_user_r, tx_user, tx_adv;
   logic [5:0] tx_pos_r;
   logic [42:0] tx_scr_r;
   logic [31:0] tx_hdr;
   logic [7:0] tx_oct;
   logic [50:0] tx_scr_out;
   always_ff @(posedge CORE_CLK) begin
      tx_req_s1_r <= tx_req_r;
      tx_req_s2_r <= tx_req_s1_r;
   end
   // no user cell at a boundary: send an idle cell
   assign tx_user = (tx_pos_r == 6'h00) ? (tx_req_s2_r != tx_ack_r) : tx_user_r;
   assign tx_adv = !LINE_TX_VALID || LINE_TX_READY;
   assign tx_hdr = tx_user ? {tx_buf[0], tx_buf[1], tx_buf[2], tx_buf[3]} : acc_pkg::IDLE_HDR;
   assign tx_scr_out = scr(tx_scr_r, tx_user ? tx_buf[tx_pos_r] : acc_pkg::IDLE_FILL, 1'b0);
   always_comb begin
      if (tx_pos_r < acc_pkg::HEC_POS) begin
         tx_oct = tx_hdr[8'(31 - 8 * tx_pos_r) -: 8];
      end else if (tx_pos_r == acc_pkg::HEC_POS) begin
         // fifth octet replaced by coset hec
         tx_oct = hec_of(tx_hdr);
      end else begin
         tx_oct = tx_scr_out[7:0];
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         tx_pos_r <= 6'h00;
         tx_user_r <= 1'b0;
         tx_ack_r <= 1'b0;
         LINE_TX_VALID <= 1'b0;
         LINE_TX_DATA <= 8'h00;
      end else if (tx_adv) begin
         LINE_TX_VALID <= 1'b1;
         LINE_TX_DATA <= tx_oct;
         tx_user_r <= tx_user;
         tx_pos_r <= (tx_pos_r == acc_pkg::LAST_POS) ? 6'h00 : tx_pos_r + 6'h01;
         if (tx_pos_r == acc_pkg::LAST_POS && tx_user) tx_ack_r <= ~tx_ack_r;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) tx_scr_r <= '0;
      else if (tx_adv && tx_pos_r >= acc_pkg::PAY_POS) tx_scr_r <= tx_scr_out[50:8];
   end

   // ---------------- receive, core side ----------------
   acc_pkg::acc_dl_t dl_r, dl_nxt;
   logic [31:0] win_r;
   logic [5:0] rx_pos_r;
   logic [2:0] cnt_r, cnt_nxt;
   logic [42:0] rx_scr_r;
   logic [50:0] rx_scr_out;
   logic [7:0] rx_buf [acc_pkg::CELL_LEN];
   logic hec_ok, at_hdr, rx_req_r, rx_ack_s1_r, rx_ack_s2_r, rx_owned, clean_r, keep_r;
   // toggled in the link domain, declared here because the core side reads it first
   logic rx_ack_r;
   assign hec_ok = (hec_of(win_r) == LINE_RX_DATA);
   assign at_hdr = LINE_RX_VALID && (rx_pos_r == acc_pkg::HEC_POS);
   assign rx_owned = (rx_req_r != rx_ack_s2_r);
   // descrambler fed with the received bits
   assign rx_scr_out = scr(rx_scr_r, LINE_RX_DATA, 1'b1);
   always_comb begin
      dl_nxt = dl_r;
      cnt_nxt = cnt_r;
      case (dl_r)
         acc_pkg::DL_SEARCH: begin
            // one good hec leaves the search
            if (LINE_RX_VALID && hec_ok) begin
               dl_nxt = acc_pkg::DL_TENTATIVE;
               cnt_nxt = 3'h0;
            end
         end
         acc_pkg::DL_TENTATIVE: begin
            if (at_hdr && !hec_ok) begin
               dl_nxt = acc_pkg::DL_SEARCH;
            end else if (at_hdr) begin
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_nxt == acc_pkg::LOCK_GOOD) begin
                  dl_nxt = acc_pkg::DL_LOCKED;
                  cnt_nxt = 3'h0;
               end
            end
         end
         acc_pkg::DL_LOCKED: begin
            if (at_hdr && hec_ok) begin
               cnt_nxt = 3'h0;
            end else if (at_hdr) begin
               // seven bad in a row drop lock
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_nxt == acc_pkg::LOSS_BAD) dl_nxt = acc_pkg::DL_SEARCH;
            end
         end
         default: begin
            dl_nxt = acc_pkg::DL_SEARCH;
            cnt_nxt = 3'h0;
         end
      endcase
   end
   always_ff @(posedge CORE_CLK) begin
      rx_ack_s1_r <= rx_ack_r;
      rx_ack_s2_r <= rx_ack_s1_r;
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         dl_r <= acc_pkg::DL_SEARCH;
         cnt_r <= 3'h0;
         win_r <= '0;
         rx_pos_r <= 6'h00;
         rx_scr_r <= '0;
      end else if (LINE_RX_VALID) begin
         dl_r <= dl_nxt;
         cnt_r <= cnt_nxt;
         // search slides octet by octet over the window
         win_r <= {win_r[23:0], LINE_RX_DATA};
         if (dl_r == acc_pkg::DL_SEARCH) rx_pos_r <= acc_pkg::PAY_POS;
         else rx_pos_r <= (rx_pos_r == acc_pkg::LAST_POS) ? 6'h00 : rx_pos_r + 6'h01;
         if (dl_r != acc_pkg::DL_SEARCH && rx_pos_r >= acc_pkg::PAY_POS)
            rx_scr_r <= rx_scr_out[50:8];
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (LINE_RX_VALID && !rx_owned)
         rx_buf[rx_pos_r] <= (rx_pos_r >= acc_pkg::PAY_POS) ? rx_scr_out[7:0] : LINE_RX_DATA;
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         clean_r <= 1'b0;
         keep_r <= 1'b0;
         rx_req_r <= 1'b0;
      end else if (LINE_RX_VALID && dl_r != acc_pkg::DL_SEARCH) begin
         if (rx_pos_r == 6'h00) clean_r <= !rx_owned;
         // keep only locked, good, non-idle cells
         if (rx_pos_r == acc_pkg::HEC_POS)
            keep_r <= clean_r && hec_ok && dl_nxt == acc_pkg::DL_LOCKED
                      && win_r != acc_pkg::IDLE_HDR;
         if (rx_pos_r == acc_pkg::LAST_POS && keep_r) rx_req_r <= ~rx_req_r;
      end
   end
   assign CELL_LOCKED = (dl_r == acc_pkg::DL_LOCKED);

   // ---------------- receive, link side ----------------
   logic rx_req_s1_r, rx_req_s2_r, rx_send;
   logic [5:0] rx_idx_r;
   always_ff @(posedge LINK.rx_clk) begin
      rx_req_s1_r <= rx_req_r;
      rx_req_s2_r <= rx_req_s1_r;
   end
   // ready only while a whole kept cell waits
   assign LINK.rx_cell_ready = rxr_s2_r && (rx_req_s2_r != rx_ack_r);
   assign rx_send = LINK.rx_enable && LINK.rx_cell_ready;
   always_ff @(posedge LINK.rx_clk) begin
      if (!rxr_s2_r) begin
         rx_idx_r <= 6'h00;
         rx_ack_r <= 1'b0;
         LINK.rx_cell_valid <= 1'b0;
         LINK.rx_cell_start <= 1'b0;
         LINK.rx_cell_data <= 8'h00;
      end else begin
         LINK.rx_cell_valid <= rx_send;
         LINK.rx_cell_start <= rx_send && rx_idx_r == 6'h00;
         if (rx_send) begin
            LINK.rx_cell_data <= rx_buf[rx_idx_r];
            rx_idx_r <= (rx_idx_r == acc_pkg::LAST_POS) ? 6'h00 : rx_idx_r + 6'h01;
            if (rx_idx_r == acc_pkg::LAST_POS) rx_ack_r <= ~rx_ack_r;
         end
      end
   end

   // ---------------- network timing reference ----------------
   logic ntr_s1_r, ntr_s2_r, ntr_s3_r;
   always_ff @(posedge CORE_CLK) begin
      ntr_s1_r <= NET_TIMING_IN;
      ntr_s2_r <= ntr_s1_r;
      ntr_s3_r <= ntr_s2_r;
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         NETWORK_TIMING_MARKER <= 1'b0;
         NET_TIMING_RECOVERED <= 1'b0;
      end else begin
         // rising edge of the 8 khz input becomes a marker
         NETWORK_TIMING_MARKER <= ntr_s2_r && !ntr_s3_r;
         // marker extracted from the line drives the output
         NET_TIMING_RECOVERED <= LINE_NTR_IN;
      end
   end
endmodule : acc_conv
`default_nettype wire

// File: verif/acc_port_sva.sv
// link port assertions for the cell convergence pair
`default_nettype none
module acc_port_sva (
   // link clocks and reset
   input wire logic tx_clk,
   input wire logic rx_clk,
   input wire logic RSTN,
   // transmit side
   input wire logic tx_cell_start,
   input wire logic tx_enable,
   input wire logic tx_cell_space_avail,
   // receive side
   input wire logic rx_cell_start,
   input wire logic rx_cell_valid,
   input wire logic rx_enable,
   input wire logic rx_cell_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tx_take;
   logic rx_take;
   logic [5:0] tx_cnt_r;
   logic [5:0] rx_cnt_r;
   logic [5:0] rx_out_r;
   assign tx_take = tx_enable && tx_cell_space_avail;
   assign rx_take = rx_enable && rx_cell_ready;
   // async clear: the link clocks stand still during reset
   always_ff @(posedge tx_clk or negedge RSTN) begin
      if (!RSTN) tx_cnt_r <= 6'h00;
      else if (tx_take) tx_cnt_r <= tx_cell_start ? 6'h01 : tx_cnt_r + 6'h01;
   end
   always_ff @(posedge rx_clk or negedge RSTN) begin
      if (!RSTN) rx_cnt_r <= 6'h00;
      else if (rx_take) rx_cnt_r <= (rx_cnt_r == 6'h34) ? 6'h00 : rx_cnt_r + 6'h01;
   end
   always_ff @(posedge rx_clk or negedge RSTN) begin
      if (!RSTN) rx_out_r <= 6'h00;
      else if (rx_cell_valid) rx_out_r <= rx_cell_start ? 6'h01 : rx_out_r + 6'h01;
   end
   AST_TX_AVAIL_DROP: assert property (@(posedge tx_clk) disable iff (!RSTN)
      tx_take && !tx_cell_start && tx_cnt_r == 6'h34 |=> !tx_cell_space_avail)
      else $error("tx space flag still up after a full cell");
   AST_TX_AVAIL_LOW: assert property (@(posedge tx_clk) disable iff (!RSTN)
      $fell(tx_cell_space_avail) |-> !tx_cell_space_avail[*3])
      else $error("tx space flag back before the cell left");
   AST_TX_START_EN: assert property (@(posedge tx_clk) disable iff (!RSTN)
      tx_cell_start |-> tx_enable)
      else $error("tx start marker without enable");
   AST_RX_ANSWER: assert property (@(posedge rx_clk) disable iff (!RSTN)
      rx_take |=> rx_cell_valid)
      else $error("rx octet missing after enable and ready");
   AST_RX_ONLY_EN: assert property (@(posedge rx_clk) disable iff (!RSTN)
      rx_cell_valid |-> $past(rx_enable) && $past(rx_cell_ready))
      else $error("rx octet driven without enable");
   AST_RX_START_POS: assert property (@(posedge rx_clk) disable iff (!RSTN)
      rx_cell_start |-> rx_cell_valid && (rx_out_r == 6'h00 || rx_out_r == 6'h35))
      else $error("rx start marker not on first octet");
   AST_RX_OCTET_POS: assert property (@(posedge rx_clk) disable iff (!RSTN)
      rx_cell_valid && !rx_cell_start |-> rx_out_r != 6'h00 && rx_out_r < 6'h35)
      else $error("rx cell longer than 53 octets");
   AST_RX_READY_DROP: assert property (@(posedge rx_clk) disable iff (!RSTN)
      rx_take && rx_cnt_r == 6'h34 |-> ##[1:3] !rx_cell_ready)
      else $error("rx ready still up after whole cell");
   COV_TX_CELL: cover property (@(posedge tx_clk) tx_take && tx_cell_start);
   COV_RX_CELL: cover property (@(posedge rx_clk) rx_cell_start);
   COV_TX_FULL: cover property (@(posedge tx_clk) $fell(tx_cell_space_avail));
endmodule : acc_port_sva
`default_nettype wire

// File: verif/test_atm_cell_convergence.sv
// bench: atm end and convergence end joined, line octets looped back
`default_nettype none
module test_atm_cell_convergence;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rstn, line_ready, stall, vld, ntr_in, ntr_line, ntr_mark, ntr_rec, locked;
   logic u_start, u_valid, u_ready, r_start, r_valid;
   logic [7:0] line_d, u_data, r_data;
   logic [15:0] bad_pat;
   logic [5:0] pos;
   logic [7:0] cell0 [53];
   logic [7:0] rx_q [$];
   logic [7:0] exp_q [$];
   int cells, octs, cyc, num_errors, checks;
   acc_if link_if ();
   acc_atm #(.DIV(12)) u_acc_atm (.LINK(link_if), .CORE_CLK(core_clk), .RSTN(rstn),
      .USER_TX_DATA(u_data), .USER_TX_START(u_start), .USER_TX_VALID(u_valid),
      .USER_TX_READY(u_ready), .USER_RX_DATA(r_data), .USER_RX_START(r_start),
      .USER_RX_VALID(r_valid));
   // header octet 0 corrupted on cells flagged in bad_pat
   acc_conv u_acc_conv (.LINK(link_if), .CORE_CLK(core_clk), .RSTN(rstn),
      .LINE_TX_DATA(line_d), .LINE_TX_VALID(vld), .LINE_TX_READY(line_ready),
      .LINE_RX_DATA(line_d ^ {7'h00, bad_pat[0] && pos == 6'h00}),
      .LINE_RX_VALID(vld && line_ready), .NET_TIMING_IN(ntr_in),
      .NETWORK_TIMING_MARKER(ntr_mark), .LINE_NTR_IN(ntr_line),
      .NET_TIMING_RECOVERED(ntr_rec), .CELL_LOCKED(locked));
   acc_port_sva u_acc_port_sva (.tx_clk(link_if.tx_clk), .rx_clk(link_if.rx_clk),
      .RSTN(rstn), .tx_cell_start(link_if.tx_cell_start), .tx_enable(link_if.tx_enable),
      .tx_cell_space_avail(link_if.tx_cell_space_avail),
      .rx_cell_start(link_if.rx_cell_start), .rx_cell_valid(link_if.rx_cell_valid),
      .rx_enable(link_if.rx_enable), .rx_cell_ready(link_if.rx_cell_ready));
   function automatic logic [7:0] hec(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
      return c ^ 8'h55;
   endfunction : hec
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(negedge core_clk) line_ready <= stall ? ~line_ready : 1'b1;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (vld && line_ready) begin
         if (octs < 53) cell0[octs] <= line_d;
         octs <= octs + 1;
         pos <= (pos == 6'h34) ? 6'h00 : pos + 6'h01;
         if (pos == 6'h00) begin
            cells <= cells + 1;
            bad_pat <= bad_pat >> 1;
         end
      end
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   always @(negedge core_clk) begin
      if (r_valid === 1'b1) begin
         if (r_start === 1'b1) check("rx_start", 8'(rx_q.size() % 53), 8'h00);
         rx_q.push_back(r_data);
      end
   end
   // idle cells on the line, then lock timing
   task automatic t_idle_lock();
      logic [42:0] s;
      logic [7:0] e;
      s = '0;
      while (locked !== 1'b1) @(negedge core_clk);
      check("lock_octets", 8'(octs >= 270 && octs <= 330), 8'h01);
      for (int i = 0; i < 4; i++) check("idle_hdr", cell0[i], 8'(i == 3));
      check("idle_hec", cell0[4], hec(32'h00000001));
      for (int i = 5; i < 53; i++) begin
         for (int b = 7; b >= 0; b--) begin
            e[b] = acc_pkg::IDLE_FILL[b] ^ s[42];
            s = {s[41:0], e[b]};
         end
         check("idle_pay", cell0[i], e);
      end
   endtask : t_idle_lock
   task automatic t_ntr();
      int hits;
      hits = 0;
      ntr_in = 1'b1;
      ntr_line = 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk);
         if (i == 0) check("ntr_rec", 8'(ntr_rec), 8'h01);
         hits += int'(ntr_mark === 1'b1);
      end
      check("ntr_marks", 8'(hits), 8'h01);
      ntr_in = 1'b0;
      ntr_line = 1'b0;
   endtask : t_ntr
   // two user cells back to back while the line stalls
   task automatic t_user_cells();
      logic [31:0] hdr;
      logic [7:0] o;
      int n;
      stall = 1'b1;
      for (int k = 0; k < 2; k++) begin
         hdr = 32'h12345670 + 32'(k * 16);
         for (int i = 0; i < 53; i++) begin
            o = (i < 4) ? hdr[31 - 8 * i -: 8] : (i == 4) ? 8'hee : 8'(i + k * 7);
            exp_q.push_back((i == 4) ? hec(hdr) : o);
            u_data = o;
            u_start = (i == 0);
            u_valid = 1'b1;
            n = 0;
            while (u_ready !== 1'b1 && n < 3000) begin
               @(negedge core_clk);
               n++;
            end
            @(negedge core_clk);
         end
      end
      u_valid = 1'b0;
      stall = 1'b0;
      n = 0;
      while (rx_q.size() < 106 && n < 5000) begin
         @(negedge core_clk);
         n++;
      end
      repeat (400) @(negedge core_clk);
      check("rx_octets", 8'(rx_q.size()), 8'd106);
      for (int i = 0; i < 106; i++) check("rx_oct", rx_q[i], exp_q[i]);
   endtask : t_user_cells
   task automatic t_delin();
      int c, lost;
      c = cells;
      lost = 0;
      bad_pat = 16'h003f;
      while (cells < c + 9) begin
         @(negedge core_clk);
         lost |= int'(locked !== 1'b1);
      end
      check("six_bad_kept", 8'(lost), 8'h00);
      c = cells;
      bad_pat = 16'h017f;
      while (locked === 1'b1 && cells < c + 20) @(negedge core_clk);
      check("loss_cell", 8'(cells - c >= 7 && cells - c <= 8), 8'h01);
      while (locked !== 1'b1 && cells < c + 40) @(negedge core_clk);
      check("relock_cell", 8'(cells - c >= 15 && cells - c <= 17), 8'h01);
   endtask : t_delin
   initial begin
      {rstn, stall, ntr_in, ntr_line, u_start, u_valid} = 6'h00;
      line_ready = 1'b1;
      u_data = 8'h00;
      bad_pat = 16'h0000;
      pos = 6'h00;
      {cells, octs, cyc, num_errors, checks} = '0;
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      t_idle_lock();
      t_ntr();
      t_user_cells();
      t_delin();
      finish_test();
   end
endmodule : test_atm_cell_convergence
`default_nettype wire
